//--- hw/tof_timer_output.sv
/*
  Output actions, event flags and interrupt/DMA masks of a 16-bit
  multifunction timer. Assumes counter, capture and DMA logic on the same
  clock that deliver one-cycle event pulses, and a register port whose
  strobes are one cycle long and never both high at once.
*/
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
module tof_timer_output (
  input  wire logic       I_MCLK,             // Block clock, 100 MHz
  input  wire logic       I_RST_N,            // Async reset, low
  input  wire logic [7:0] I_ADDR,             // Register address
  input  wire logic [7:0] I_WDATA,            // Write data
  input  wire logic       I_WR,               // Write strobe
  input  wire logic       I_RD,               // Read strobe
  output logic      [7:0] O_RDATA,            // Read data, next cycle
  input  wire logic       I_MATCH0,           // Compare 0 match pulse
  input  wire logic       I_MATCH1,           // Compare 1 match pulse
  input  wire logic       I_WRAP,             // Overflow or underflow pulse
  input  wire logic       I_CAPTURE0,         // Capture into register 0
  input  wire logic       I_CAPTURE1,         // Capture into register 1
  input  wire logic       I_BICAPTURE_MODE,   // Bicapture mode level
  input  wire logic       I_OUTPUT_A_ENABLE,  // Output A enable level
  input  wire logic       I_OUTPUT_B_ENABLE,  // Output B enable level
  input  wire logic       I_CAPTURE0_EOB,     // Capture 0 DMA block end
  input  wire logic       I_MATCH0_EOB,       // Compare 0 DMA block end
  output logic            O_TIMER_OUTPUT_A,   // Output A pin
  output logic            O_TIMER_OUTPUT_B,   // Output B pin
  output logic            O_EVENT_PULSE,      // On-chip event pulse
  output logic            O_TIMER_IRQ,        // Interrupt request level
  output logic            O_CAPTURE0_DMA_REQ, // Capture 0 DMA request
  output logic            O_MATCH0_DMA_REQ,   // Compare 0 DMA request
  output logic            O_SW_CAPTURE0,      // Software capture 0 pulse
  output logic            O_SW_CAPTURE1       // Software capture 1 pulse
);
  import tof_pkg::*;

  // ==========================================================
  // Declarations
  tof_out_ctrl_type ctrl [OUTPUT_COUNT];
  tof_out_ctrl_type next_ctrl [OUTPUT_COUNT];
  logic             wr_ctrl [OUTPUT_COUNT];
  logic             out_enable [OUTPUT_COUNT];
  logic             out_level [OUTPUT_COUNT];
  logic             out_pin [OUTPUT_COUNT];
  tof_events_type   events;
  tof_flags_type    flags;
  tof_flags_type    next_flags;
  tof_flags_type    wflags;
  tof_mask_type     mask;
  tof_mask_type     next_mask;
  tof_mask_type     wmask;
  logic             hit_a;
  logic             hit_b;
  logic             hit_flags;
  logic             hit_mask;
  logic             wr_flags;
  logic             wr_mask;
  logic             sw_capture0;
  logic             sw_capture1;
  logic             capture0_to_flag;
  logic             match0_to_flag;
  logic             capture0_set;
  logic             capture1_set;
  logic             match0_set;
  logic             capture0_overrun_set;
  logic             match0_overrun_set;
  logic             next_event_pulse;
  logic [7:0]       read_a;
  logic [7:0]       read_b;
  logic [7:0]       read_mux;
  logic [7:0]       next_rdata;

  // ==========================================================
  // Address decode
  assign hit_a     = (I_ADDR == ADDR_OUTPUT_A_CONTROL);
  assign hit_b     = (I_ADDR == ADDR_OUTPUT_B_CONTROL);
  assign hit_flags = (I_ADDR == ADDR_TIMER_EVENT_FLAGS);
  assign hit_mask  = (I_ADDR == ADDR_IRQ_DMA_MASK);
  assign wr_flags  = I_WR & hit_flags;
  assign wr_mask   = I_WR & hit_mask;
  assign wflags    = tof_flags_type'(I_WDATA);
  assign wmask     = tof_mask_type'(I_WDATA);

  assign wr_ctrl[0]    = I_WR & hit_a;
  assign wr_ctrl[1]    = I_WR & hit_b;
  assign out_enable[0] = I_OUTPUT_A_ENABLE;
  assign out_enable[1] = I_OUTPUT_B_ENABLE;
  assign events        = '{match0: I_MATCH0, match1: I_MATCH1, wrap: I_WRAP};

  // ==========================================================
  // Output channels
  // Both outputs see the same events; only their control register and enable input differ.
  for (genvar ch = 0; ch < OUTPUT_COUNT; ch++) begin : g_out
    assign next_ctrl[ch] = wr_ctrl[ch] ? tof_out_ctrl_type'(I_WDATA) : ctrl[ch];

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
        ctrl[ch] <= tof_out_ctrl_type'(RESET_OUTPUT_CONTROL);
      end else begin
        ctrl[ch] <= next_ctrl[ch];
      end
    end

    tof_out_action u_action (
      .i_clk          (I_MCLK),
      .i_rst_n        (I_RST_N),
      .i_ctrl         (ctrl[ch]),
      .i_events       (events),
      .i_preset_load  (wr_ctrl[ch]),
      .i_preset_value (I_WDATA[0]),
      .i_enable       (out_enable[ch]),
      .o_level        (out_level[ch]),
      .o_pin          (out_pin[ch])
    );
  end

  assign O_TIMER_OUTPUT_A = out_pin[0];
  assign O_TIMER_OUTPUT_B = out_pin[1];

  // ==========================================================
  // On-chip event pulse
  // match0 pulse gated by output A control, wrap pulse gated by output B control
  assign next_event_pulse = (I_MATCH0 & ctrl[0].event_pulse_enable)
                          | (I_WRAP & ctrl[1].event_pulse_enable);

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_EVENT_PULSE <= 1'b0;
    end else begin
      O_EVENT_PULSE <= next_event_pulse;
    end
  end

  // ==========================================================
  // Flag set terms
  // With DMA enabled a capture or match feeds the DMA channel instead of
  // the flag; the flag then marks block end, which makes the masked flag
  // act as the block-end interrupt once the DMA enable drops.
  // software captures 0 and 1
  assign sw_capture0 = wr_flags & wflags.capture0_flag;
  assign sw_capture1 = wr_flags & wflags.capture1_flag & ~I_BICAPTURE_MODE;

  assign capture0_to_flag = I_CAPTURE0 & ~mask.capture0_dma_enable;
  assign match0_to_flag   = I_MATCH0 & ~mask.match0_dma_enable;

  assign capture0_set = capture0_to_flag | I_CAPTURE0_EOB | sw_capture0;
  assign capture1_set = I_CAPTURE1 | sw_capture1;
  assign match0_set   = match0_to_flag | I_MATCH0_EOB;

  assign capture0_overrun_set = (capture0_to_flag & flags.capture0_flag) | sw_capture0;
  assign match0_overrun_set   = match0_to_flag & flags.match0_flag;

  // ==========================================================
  // Flag next values
  // Writing 0 clears a flag, writing 1 leaves it (a 1 to capture0_flag, or capture1_flag outside bicapture mode, sets it); a set in the same cycle
  // as the clearing write wins so no event is lost.
  // software-only clear
  assign next_flags.capture0_flag = capture0_set
                                  | (flags.capture0_flag & ~(wr_flags & ~wflags.capture0_flag));
  assign next_flags.capture1_flag = capture1_set
                                  | (flags.capture1_flag & ~(wr_flags & ~wflags.capture1_flag));
  assign next_flags.match0_flag = match0_set
                                | (flags.match0_flag & ~(wr_flags & ~wflags.match0_flag));
  assign next_flags.match1_flag = I_MATCH1
                                | (flags.match1_flag & ~(wr_flags & ~wflags.match1_flag));
  assign next_flags.wrap_flag = I_WRAP
                              | (flags.wrap_flag & ~(wr_flags & ~wflags.wrap_flag));
  assign next_flags.capture0_overrun = capture0_overrun_set
                                     | (flags.capture0_overrun & ~(wr_flags & ~wflags.capture0_overrun));
  assign next_flags.match0_overrun = match0_overrun_set
                                   | (flags.match0_overrun & ~(wr_flags & ~wflags.match0_overrun));
  assign next_flags.capture_irq_and_select = wr_flags ? wflags.capture_irq_and_select
                                                      : flags.capture_irq_and_select;

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      flags <= tof_flags_type'(RESET_TIMER_EVENT_FLAGS);
    end else begin
      flags <= next_flags;
    end
  end

  // ==========================================================
  // Mask register
  // A software set of a DMA enable in the block-end cycle wins, so a new
  // block can be started without a gap.
  assign next_mask.timer_irq_global_enable = wr_mask ? wmask.timer_irq_global_enable
                                                     : mask.timer_irq_global_enable;
  assign next_mask.capture0_dma_enable = wr_mask ? wmask.capture0_dma_enable
                                                 : (mask.capture0_dma_enable & ~I_CAPTURE0_EOB);
  assign next_mask.capture0_irq_mask = wr_mask ? wmask.capture0_irq_mask : mask.capture0_irq_mask;
  assign next_mask.capture1_irq_mask = wr_mask ? wmask.capture1_irq_mask : mask.capture1_irq_mask;
  assign next_mask.match0_dma_enable = wr_mask ? wmask.match0_dma_enable
                                               : (mask.match0_dma_enable & ~I_MATCH0_EOB);
  assign next_mask.match0_irq_mask = wr_mask ? wmask.match0_irq_mask : mask.match0_irq_mask;
  assign next_mask.match1_irq_mask = wr_mask ? wmask.match1_irq_mask : mask.match1_irq_mask;
  assign next_mask.wrap_irq_mask   = wr_mask ? wmask.wrap_irq_mask : mask.wrap_irq_mask;

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mask <= tof_mask_type'(RESET_IRQ_DMA_MASK);
    end else begin
      mask <= next_mask;
    end
  end

  // ==========================================================
  // DMA requests and software capture strobes
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CAPTURE0_DMA_REQ <= 1'b0;
      O_MATCH0_DMA_REQ   <= 1'b0;
      O_SW_CAPTURE0      <= 1'b0;
      O_SW_CAPTURE1      <= 1'b0;
    end else begin
      O_CAPTURE0_DMA_REQ <= I_CAPTURE0 & mask.capture0_dma_enable;
      O_MATCH0_DMA_REQ   <= I_MATCH0 & mask.match0_dma_enable;
      O_SW_CAPTURE0      <= sw_capture0;
      O_SW_CAPTURE1      <= sw_capture1;
    end
  end

  // ==========================================================
  // Interrupt request
  // gated level
  tof_irq_combine u_irq (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_flags (flags),
    .i_mask  (mask),
    .o_irq   (O_TIMER_IRQ)
  );

  // ==========================================================
  // Read path
  // live level readback
  assign read_a = {ctrl[0][7:1], out_level[0]};
  assign read_b = {ctrl[1][7:1], out_level[1]};

  assign read_mux = hit_a     ? read_a :
                    hit_b     ? read_b :
                    hit_flags ? 8'(flags) :
                    hit_mask  ? 8'(mask) : READ_UNMAPPED;
  // Data stands only in the cycle after the strobe
  assign next_rdata = I_RD ? read_mux : READ_UNMAPPED;

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RDATA <= READ_UNMAPPED;
    end else begin
      O_RDATA <= next_rdata;
    end
  end

endmodule

//--- hw/tof_pkg.sv
/*
  Shared constants and types of the timer output, flag and mask logic.
  Assumes an 8-bit register port with byte addresses and events that
  arrive as one-cycle pulses on the block clock.
*/
package tof_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_OUTPUT_A_CONTROL = 8'hFC;
  localparam logic [7:0] ADDR_OUTPUT_B_CONTROL = 8'hFD;
  localparam logic [7:0] ADDR_TIMER_EVENT_FLAGS = 8'hFE;
  localparam logic [7:0] ADDR_IRQ_DMA_MASK = 8'hFF;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RESET_OUTPUT_CONTROL = 8'h00;
  localparam logic [7:0] RESET_TIMER_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] RESET_IRQ_DMA_MASK = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic       RESET_OUTPUT_LEVEL = 1'b0;
  localparam logic       DISABLED_PIN_LEVEL = 1'b1;
  localparam int         OUTPUT_COUNT = 2;

  // ==========================================================
  // Action codes, first action bit in the upper position
  localparam logic [1:0] ACT_SET = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_KEEP = 2'h3;

  // ==========================================================
  // Register layouts, most significant field first
  typedef struct packed {
    logic [1:0] match0_action;
    logic [1:0] match1_action;
    logic [1:0] wrap_action;
    logic       event_pulse_enable;
    logic       output_preset_level;
  } tof_out_ctrl_type;

  typedef struct packed {
    logic capture0_flag;
    logic capture1_flag;
    logic match0_flag;
    logic match1_flag;
    logic wrap_flag;
    logic capture0_overrun;
    logic match0_overrun;
    logic capture_irq_and_select;
  } tof_flags_type;

  typedef struct packed {
    logic timer_irq_global_enable;
    logic capture0_dma_enable;
    logic capture0_irq_mask;
    logic capture1_irq_mask;
    logic match0_dma_enable;
    logic match0_irq_mask;
    logic match1_irq_mask;
    logic wrap_irq_mask;
  } tof_mask_type;

  typedef struct packed {
    logic match0;
    logic match1;
    logic wrap;
  } tof_events_type;

endpackage

//--- hw/tof_out_action.sv
/*
  One timer output: merges the actions of simultaneous events and keeps
  the output level. Assumes event pulses on the block clock and a preset
  load pulse from the register port.
*/
`timescale 1ns/1ns
module tof_out_action (
  input  wire logic                      i_clk,          // Block clock
  input  wire logic                      i_rst_n,        // Async reset, low
  input  wire tof_pkg::tof_out_ctrl_type i_ctrl,         // Action fields
  input  wire tof_pkg::tof_events_type   i_events,       // Event pulses
  input  wire logic                      i_preset_load,  // Preset write
  input  wire logic                      i_preset_value, // Preset level
  input  wire logic                      i_enable,       // Output enable
  output logic                           o_level,        // Internal level
  output logic                           o_pin           // Pin level
);
  import tof_pkg::*;

  logic [1:0] match0_term;
  logic [1:0] match1_term;
  logic [1:0] wrap_term;
  logic [1:0] combined;
  logic       base_level;
  logic       next_level;

  // ==========================================================
  // Action merge
  // bitwise AND merge
  assign match0_term = i_events.match0 ? i_ctrl.match0_action : ACT_KEEP;
  assign match1_term = i_events.match1 ? i_ctrl.match1_action : ACT_KEEP;
  assign wrap_term   = i_events.wrap ? i_ctrl.wrap_action : ACT_KEEP;
  assign combined    = match0_term & match1_term & wrap_term;
  assign base_level  = i_preset_load ? i_preset_value : o_level;

  always_comb begin
    case (combined)
      ACT_SET:    next_level = 1'b1;
      ACT_TOGGLE: next_level = ~base_level;
      ACT_CLEAR:  next_level = 1'b0;
      default:    next_level = base_level;
    endcase
  end

  // ==========================================================
  // Level and pin
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= RESET_OUTPUT_LEVEL;
      o_pin   <= DISABLED_PIN_LEVEL;
    end else begin
      o_level <= next_level;
      o_pin   <= i_enable ? next_level : DISABLED_PIN_LEVEL;
    end
  end

endmodule

//--- hw/tof_irq_combine.sv
/*
  Timer interrupt request: flags gated by masks and the global enable.
  Assumes flag and mask registers on the block clock.
*/
`timescale 1ns/1ns
module tof_irq_combine (
  input  wire logic                   i_clk,   // Block clock
  input  wire logic                   i_rst_n, // Async reset, low
  input  wire tof_pkg::tof_flags_type i_flags, // Flag register
  input  wire tof_pkg::tof_mask_type  i_mask,  // Mask register
  output logic                        o_irq    // Level request
);
  import tof_pkg::*;

  logic capture0_term;
  logic capture1_term;
  logic capture_term;
  logic match_wrap_term;
  logic next_irq;

  // ==========================================================
  // Source gating
  assign capture0_term = i_flags.capture0_flag & i_mask.capture0_irq_mask;
  assign capture1_term = i_flags.capture1_flag & i_mask.capture1_irq_mask;
  assign capture_term = i_flags.capture_irq_and_select ? (capture0_term & capture1_term)
                                                       : (capture0_term | capture1_term);
  assign match_wrap_term = (i_flags.match0_flag & i_mask.match0_irq_mask)
                         | (i_flags.match1_flag & i_mask.match1_irq_mask)
                         | (i_flags.wrap_flag & i_mask.wrap_irq_mask);
  assign next_irq = i_mask.timer_irq_global_enable & (capture_term | match_wrap_term);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= next_irq;
    end
  end

endmodule

//--- test/tof_timer_output_asserts.sv
/*
  Port-level checks of the timer output block.
  Assumes it is bound onto tof_timer_output, one clock domain.
*/
`timescale 1ns/1ns
module tof_checker (
  input wire logic       I_MCLK,             // Clock
  input wire logic       I_RST_N,            // Reset, low
  input wire logic [7:0] I_ADDR,             // Address
  input wire logic [7:0] I_WDATA,            // Write data
  input wire logic       I_WR,               // Write strobe
  input wire logic       I_RD,               // Read strobe
  input wire logic [7:0] O_RDATA,            // Read data
  input wire logic       I_MATCH0,           // Match 0
  input wire logic       I_WRAP,             // Wrap
  input wire logic       I_CAPTURE0,         // Capture 0
  input wire logic       I_BICAPTURE_MODE,   // Bicapture
  input wire logic       I_OUTPUT_A_ENABLE,  // Enable A
  input wire logic       O_TIMER_OUTPUT_A,   // Pin A
  input wire logic       O_EVENT_PULSE,      // Event pulse
  input wire logic       O_TIMER_IRQ,        // Interrupt
  input wire logic       O_CAPTURE0_DMA_REQ, // DMA req 0
  input wire logic       O_MATCH0_DMA_REQ,   // DMA req match
  input wire logic       O_SW_CAPTURE0,      // Soft capture 0
  input wire logic       O_SW_CAPTURE1       // Soft capture 1
);
  // ==========================================================
  // Mirror of the global enable, needed to judge the request
  logic global_on;
  wire  fe_wr = I_WR && I_ADDR == 8'hFE;
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      global_on <= 1'b0;
    end else if (I_WR && I_ADDR == 8'hFF) begin
      global_on <= I_WDATA[7];
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  rd_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data not idle");
  unmapped_rd_a: assert property (I_RD && I_ADDR < 8'hFC |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
  pin_a_high_a: assert property (!I_OUTPUT_A_ENABLE |=> O_TIMER_OUTPUT_A)
    else $error("disabled pin not high");
  event_cause_a: assert property (O_EVENT_PULSE |-> $past(I_MATCH0) || $past(I_WRAP))
    else $error("event pulse without cause");
  irq_global_a: assert property (!global_on |=> !O_TIMER_IRQ)
    else $error("request with global off");
  sw_cap0_a: assert property (fe_wr && I_WDATA[7] |=> O_SW_CAPTURE0)
    else $error("no soft capture 0");
  sw_cap0_cause_a: assert property (O_SW_CAPTURE0 |-> $past(fe_wr) && $past(I_WDATA[7]))
    else $error("stray soft capture 0");
  sw_cap1_a: assert property (fe_wr && I_WDATA[6] |=> O_SW_CAPTURE1 == !$past(I_BICAPTURE_MODE))
    else $error("soft capture 1 wrong");
  cap_dma_a: assert property (O_CAPTURE0_DMA_REQ |-> $past(I_CAPTURE0))
    else $error("stray capture DMA request");
  match_dma_a: assert property (O_MATCH0_DMA_REQ |-> $past(I_MATCH0))
    else $error("stray match DMA request");
endmodule

bind tof_timer_output tof_checker u_chk (.I_MCLK, .I_RST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
  .I_MATCH0, .I_WRAP, .I_CAPTURE0, .I_BICAPTURE_MODE, .I_OUTPUT_A_ENABLE, .O_TIMER_OUTPUT_A,
  .O_EVENT_PULSE, .O_TIMER_IRQ, .O_CAPTURE0_DMA_REQ, .O_MATCH0_DMA_REQ, .O_SW_CAPTURE0, .O_SW_CAPTURE1);

//--- test/tof_dma_model.sv
/*
  Behavioural transfer controller: counts requests, flags block end.
  Assumes one-cycle request pulses on the block clock.
*/
`timescale 1ns/1ns
module tof_dma_model #(
  parameter int BLOCK_LEN = 2
) (
  input  wire logic i_clk,   // Block clock
  input  wire logic i_rst_n, // Reset, low
  input  wire logic i_req,   // Transfer request
  output logic      o_eob    // Block end pulse
);
  int count;
  // block end after the last transfer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= 0;
      o_eob <= 1'b0;
    end else begin
      o_eob <= i_req && count == BLOCK_LEN - 1;
      if (i_req) begin
        count <= (count == BLOCK_LEN - 1) ? 0 : count + 1;
      end
    end
  end
endmodule

//--- test/tof_timer_output_test.sv
/*
  Self-checking bench of the timer output block.
  Assumes two transfer controller models close the DMA loops.
*/
`timescale 1ns/1ns
module tof_timer_output_test;
  import tof_pkg::*;
  logic [7:0] addr, wdata, rdata;
  logic       clk, rst_n, wr, rd, m0, m1, wrap, c0, c1, bicap, en_a, en_b;
  logic       eob_c, eob_m, out_a, out_b, evp, irq, dreq_c, dreq_m, swc0, swc1;
  int         n_fail, n_checks;

  tof_timer_output u_dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_MATCH0(m0), .I_MATCH1(m1), .I_WRAP(wrap), .I_CAPTURE0(c0),
    .I_CAPTURE1(c1), .I_BICAPTURE_MODE(bicap), .I_OUTPUT_A_ENABLE(en_a), .I_OUTPUT_B_ENABLE(en_b),
    .I_CAPTURE0_EOB(eob_c), .I_MATCH0_EOB(eob_m), .O_TIMER_OUTPUT_A(out_a), .O_TIMER_OUTPUT_B(out_b),
    .O_EVENT_PULSE(evp), .O_TIMER_IRQ(irq), .O_CAPTURE0_DMA_REQ(dreq_c), .O_MATCH0_DMA_REQ(dreq_m),
    .O_SW_CAPTURE0(swc0), .O_SW_CAPTURE1(swc1));
  tof_dma_model #(.BLOCK_LEN(2)) u_dma_c (.i_clk(clk), .i_rst_n(rst_n), .i_req(dreq_c), .o_eob(eob_c));
  tof_dma_model #(.BLOCK_LEN(2)) u_dma_m (.i_clk(clk), .i_rst_n(rst_n), .i_req(dreq_m), .o_eob(eob_m));

  always #5 clk = ~clk;

  // ==========================================================
  // Bus, event and compare helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // Event vector order: match0, match1, wrap, capture0, capture1
  task automatic ev(input logic [4:0] e);
    @(posedge clk);
    {m0, m1, wrap, c0, c1} <= e;
    @(posedge clk);
    {m0, m1, wrap, c0, c1} <= 5'h00;
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 10) begin
      idle(1);
      k++;
    end
    chk(irq, 1);
    if (irq !== 1'b1) begin
      complete_run;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    for (int a = 8'hFC; a <= 8'hFF; a++) begin
      rd_chk(8'(a), 8'h00);
    end
    wr_reg(8'h10, 8'hFF);
    rd_chk(8'h10, 8'h00);
    wr_reg(ADDR_IRQ_DMA_MASK, 8'h35);
    rd_chk(ADDR_IRQ_DMA_MASK, 8'h35);
    $display("regs done");
  endtask
  task automatic t_actions;
    logic [7:0] ctl;
    logic       lvl;
    for (int o = 0; o < 2; o++) begin
      for (int e = 0; e < 3; e++) begin
        for (int p = 0; p < 2; p++) begin
          for (int c = 0; c < 4; c++) begin
            ctl = 8'hFC;
            ctl[7 - 2 * e -: 2] = 2'(c);
            ctl[0] = 1'(p);
            lvl = (c == 0) ? 1'b1 : (c == 1) ? !p : (c == 2) ? 1'b0 : 1'(p);
            wr_reg(8'hFC + 8'(o), ctl);
            ev(5'h10 >> e);
            chk(o ? out_b : out_a, lvl);
            rd_chk(8'hFC + 8'(o), {ctl[7:1], lvl});
          end
        end
      end
    end
    en_a <= 1'b0;
    en_b <= 1'b0;
    idle(1);
    chk({out_a, out_b}, 2'b11);
    en_a <= 1'b1;
    en_b <= 1'b1;
    $display("actions done");
  endtask
  task automatic t_merge;
    logic [7:0] ctl [3] = '{8'h6D, 8'h79, 8'hF5};
    logic [4:0] evs [3] = '{5'h18, 5'h1C, 5'h0C};
    logic       lvl [3] = '{1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      wr_reg(ADDR_OUTPUT_A_CONTROL, ctl[i]);
      ev(evs[i]);
      chk(out_a, lvl[i]);
    end
    $display("merge done");
  endtask
  task automatic t_pulse;
    wr_reg(ADDR_OUTPUT_A_CONTROL, 8'hFE);
    ev(5'h10);
    chk(evp, 1);
    idle(1);
    chk(evp, 0);
    ev(5'h08);
    chk(evp, 0);
    wr_reg(ADDR_OUTPUT_A_CONTROL, 8'hFC);
    ev(5'h10);
    chk(evp, 0);
    wr_reg(ADDR_OUTPUT_B_CONTROL, 8'hFE);
    ev(5'h04);
    chk(evp, 1);
    wr_reg(ADDR_OUTPUT_B_CONTROL, 8'hFC);
    ev(5'h04);
    chk(evp, 0);
    $display("pulse done");
  endtask
  task automatic t_flags;
    for (int e = 0; e < 3; e++) begin
      wr_reg(ADDR_TIMER_EVENT_FLAGS, 8'h00);
      wr_reg(ADDR_IRQ_DMA_MASK, 8'h80 | (8'h07 & ~(8'h04 >> e)));
      ev(5'h10 >> e);
      idle(2);
      chk(irq, 0);
      wr_reg(ADDR_IRQ_DMA_MASK, 8'h04 >> e);
      idle(2);
      chk(irq, 0);
      rd_chk(ADDR_TIMER_EVENT_FLAGS, 8'h20 >> e);
      wr_reg(ADDR_IRQ_DMA_MASK, 8'h80 | (8'h04 >> e));
      wait_irq;
      idle(4);
      chk(irq, 1);
      wr_reg(ADDR_TIMER_EVENT_FLAGS, 8'h00);
      idle(2);
      chk(irq, 0);
    end
    ev(5'h10);
    ev(5'h10);
    rd_chk(ADDR_TIMER_EVENT_FLAGS, 8'h22);
    $display("flags done");
  endtask
  task automatic t_capture;
    wr_reg(ADDR_TIMER_EVENT_FLAGS, 8'h80);
    chk(swc0, 1);
    rd_chk(ADDR_TIMER_EVENT_FLAGS, 8'h84);
    wr_reg(ADDR_TIMER_EVENT_FLAGS, 8'h00);
    bicap <= 1'b1;
    wr_reg(ADDR_TIMER_EVENT_FLAGS, 8'h40);
    chk(swc1, 0);
    rd_chk(ADDR_TIMER_EVENT_FLAGS, 8'h00);
    bicap <= 1'b0;
    wr_reg(ADDR_TIMER_EVENT_FLAGS, 8'h40);
    chk(swc1, 1);
    rd_chk(ADDR_TIMER_EVENT_FLAGS, 8'h40);
    wr_reg(ADDR_TIMER_EVENT_FLAGS, 8'h00);
    ev(5'h02);
    ev(5'h02);
    rd_chk(ADDR_TIMER_EVENT_FLAGS, 8'h84);
    wr_reg(ADDR_TIMER_EVENT_FLAGS, 8'h01);
    wr_reg(ADDR_IRQ_DMA_MASK, 8'hA0);
    ev(5'h02);
    idle(2);
    chk(irq, 0);
    wr_reg(ADDR_IRQ_DMA_MASK, 8'hB0);
    ev(5'h01);
    wait_irq;
    wr_reg(ADDR_TIMER_EVENT_FLAGS, 8'h00);
    idle(2);
    chk(irq, 0);
    ev(5'h02);
    wait_irq;
    wr_reg(ADDR_TIMER_EVENT_FLAGS, 8'h00);
    $display("capture done");
  endtask
  task automatic t_dma;
    wr_reg(ADDR_IRQ_DMA_MASK, 8'hE0);
    ev(5'h02);
    chk(dreq_c, 1);
    rd_chk(ADDR_TIMER_EVENT_FLAGS, 8'h00);
    ev(5'h02);
    wait_irq;
    rd_chk(ADDR_IRQ_DMA_MASK, 8'hA0);
    rd_chk(ADDR_TIMER_EVENT_FLAGS, 8'h80);
    wr_reg(ADDR_TIMER_EVENT_FLAGS, 8'h00);
    wr_reg(ADDR_IRQ_DMA_MASK, 8'h8C);
    ev(5'h10);
    chk(dreq_m, 1);
    ev(5'h10);
    wait_irq;
    rd_chk(ADDR_IRQ_DMA_MASK, 8'h84);
    rd_chk(ADDR_TIMER_EVENT_FLAGS, 8'h20);
    $display("dma done");
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {addr, wdata} = 16'h0000;
    {wr, rd, m0, m1, wrap, c0, c1, bicap} = 8'h00;
    {en_a, en_b} = 2'b11;
    n_fail = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    idle(1);
    chk({out_a, out_b}, 2'b00);
    t_regs;
    t_actions;
    t_merge;
    t_pulse;
    t_flags;
    t_capture;
    t_dma;
    complete_run;
  end
endmodule
